/* hw/csa_port.sv */
// socket-A card port: address strobe, byte enables, wait stretch, input-port sensing
`timescale 1ns/1ps
`default_nettype none
// Function
// - pulse the address latch strobe when a socket-A access starts.
// - even byte enable drives even-addressed byte transfers.
// - odd byte enable drives odd-addressed byte transfers.
// - card holding wait low keeps the transaction from completing.
// - sample the eight input-port lines continuously into the level register.
// - record each input-port line change in a sticky change register.
// - sample port-size input when an i/o access starts; asserted means 16-bit.
module csa_port (
  input wire logic sys_clk_i, // 200 mhz system clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic clk_en_i, // freezes all state while low
  input wire logic req_valid_i, // start a socket-A access
  input wire csa_pkg::csa_req_s req_i, // access attributes
  input wire logic wait_n_i, // card wait pin, low stretches
  input wire logic [csa_pkg::IP_WIDTH-1:0] input_port_i, // card input-port pins
  input wire logic [csa_pkg::IP_WIDTH-1:0] change_clr_i, // write-one-to-clear change bits
  output logic busy_o, // transaction in progress
  output logic done_o, // one-cycle pulse at completion
  output logic sock_a_addr_latch_o, // address latch strobe, high for one cycle
  output logic sock_a_even_byte_en_n_o, // even byte card enable, active low
  output logic sock_a_odd_byte_en_n_o, // odd byte card enable, active low
  output logic io16_o, // port size seen at last i/o start
  output logic [csa_pkg::IP_WIDTH-1:0] pin_input_level_reg_o, // current line levels
  output logic [csa_pkg::IP_WIDTH-1:0] pin_status_change_reg_o // sticky change flags
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the card pins are asynchronous to the system clock
  logic [csa_pkg::IP_WIDTH-1:0] ip_meta_ff, ip_sync_ff;
  logic wait_meta_ff, wait_sync_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ip_meta_ff <= csa_pkg::IP_RESET;
      ip_sync_ff <= csa_pkg::IP_RESET;
      wait_meta_ff <= 1'b1;
      wait_sync_ff <= 1'b1;
    end else if (clk_en_i) begin
      ip_meta_ff <= input_port_i;
      ip_sync_ff <= ip_meta_ff;
      wait_meta_ff <= wait_n_i;
      wait_sync_ff <= wait_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input-port level and change registers
  logic [csa_pkg::IP_WIDTH-1:0] level_ff, change_ff;
  logic [csa_pkg::IP_WIDTH-1:0] nxt_change;
  genvar gi;
  // per line: a new edge wins over a clear in the same cycle so none is lost
  generate
    for (gi = 0; gi < csa_pkg::IP_WIDTH; gi++) begin : g_line
      assign nxt_change[gi] = (ip_sync_ff[gi] != level_ff[gi]) | (change_ff[gi] & ~change_clr_i[gi]);
    end
  endgenerate
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      level_ff <= csa_pkg::IP_RESET;
      change_ff <= '0;
    end else if (clk_en_i) begin
      level_ff <= ip_sync_ff;
      change_ff <= nxt_change;
    end
  end
  // first sample after reset may flag lines already high; software clears them
  assign pin_input_level_reg_o = level_ff;
  assign pin_status_change_reg_o = change_ff;

  ////////////////////////////////////////////////////////////////////////////
  // transaction sequencer: addr cycle, data cycles stretched by wait, done
  csa_pkg::csa_state_e state_ff, nxt_state;
  logic start, data_end, wide_now, nxt_busy;
  logic even_n_ff, odd_n_ff, ale_ff, done_ff, io16_ff, busy_ff, settled_ff;
  // a request is taken only in idle; one that arrives while busy is dropped, not queued
  assign start = (state_ff == csa_pkg::ST_IDLE) && req_valid_i;
  // port size pin is the synchronised shared input-port line
  assign wide_now = req_i.is_io ? ip_sync_ff[csa_pkg::IOIS16_BIT] : req_i.wide;
  // the wait synchroniser lags the pin by two edges, so wait is trusted only from the
  // second data cycle on: a card that pulls wait low in answer to the strobe is always seen,
  // at the cost of one extra cycle on every access
  assign data_end = (state_ff == csa_pkg::ST_DATA) && settled_ff && wait_sync_ff;
  // busy is registered from the next state so the output comes straight from a flop
  assign nxt_busy = (nxt_state != csa_pkg::ST_IDLE);
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      csa_pkg::ST_IDLE: if (req_valid_i) nxt_state = csa_pkg::ST_ADDR;
      csa_pkg::ST_ADDR: nxt_state = csa_pkg::ST_DATA;
      csa_pkg::ST_DATA: if (data_end) nxt_state = csa_pkg::ST_DONE;
      csa_pkg::ST_DONE: nxt_state = csa_pkg::ST_IDLE;
      default: nxt_state = csa_pkg::ST_IDLE;
    endcase
  end
  // enables latch at start and hold to done; released on the done cycle
  // they are kept active low in their flops so the pins need no gate after the register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_ff <= csa_pkg::ST_IDLE;
      busy_ff <= 1'b0;
      settled_ff <= 1'b0;
      even_n_ff <= 1'b1;
      odd_n_ff <= 1'b1;
      ale_ff <= 1'b0;
      done_ff <= 1'b0;
      io16_ff <= 1'b0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      settled_ff <= (state_ff == csa_pkg::ST_DATA);
      ale_ff <= start;
      done_ff <= data_end;
      if (start) begin
        even_n_ff <= ~(wide_now | ~req_i.addr_lsb);
        odd_n_ff <= ~(wide_now | req_i.addr_lsb);
        if (req_i.is_io) io16_ff <= ip_sync_ff[csa_pkg::IOIS16_BIT];
      end else if (data_end) begin
        even_n_ff <= 1'b1;
        odd_n_ff <= 1'b1;
      end
    end
  end
  // every pin and status output comes straight from a flop
  assign sock_a_addr_latch_o = ale_ff;
  assign sock_a_even_byte_en_n_o = even_n_ff;
  assign sock_a_odd_byte_en_n_o = odd_n_ff;
  assign done_o = done_ff;
  assign busy_o = busy_ff;
  assign io16_o = io16_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // an access taken at this edge
  sequence s_start;
    start && clk_en_i;
  endsequence
  // a data cycle in which the synchronised wait is still low
  sequence s_held;
    (state_ff == csa_pkg::ST_DATA) && !wait_sync_ff;
  endsequence
  // strobe: one pulse per access, only in the address cycle, never for a dropped request
  property p_ale;
    @(posedge sys_clk_i) disable iff (reset_i) s_start |=> sock_a_addr_latch_o;
  endproperty
  a_ale: assert property (p_ale) else $error("strobe missing after start");
  property p_ale_once;
    @(posedge sys_clk_i) disable iff (reset_i) sock_a_addr_latch_o |-> (state_ff == csa_pkg::ST_ADDR);
  endproperty
  a_ale_once: assert property (p_ale_once) else $error("strobe outside address cycle");
  property p_refuse;
    @(posedge sys_clk_i) disable iff (reset_i)
      busy_o && req_valid_i && clk_en_i |=> !sock_a_addr_latch_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request taken while busy");
  property p_busy;
    @(posedge sys_clk_i) disable iff (reset_i)
      s_start |=> busy_o && !done_o;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised at start");
  // byte enables: chosen at start, idle outside an access, dropped at completion
  property p_even;
    @(posedge sys_clk_i) disable iff (reset_i) (s_start and (!wide_now && !req_i.addr_lsb))
      |=> !sock_a_even_byte_en_n_o && sock_a_odd_byte_en_n_o;
  endproperty
  a_even: assert property (p_even) else $error("even byte enable wrong");
  property p_odd;
    @(posedge sys_clk_i) disable iff (reset_i) (s_start and (!wide_now && req_i.addr_lsb))
      |=> sock_a_even_byte_en_n_o && !sock_a_odd_byte_en_n_o;
  endproperty
  a_odd: assert property (p_odd) else $error("odd byte enable wrong");
  property p_idle_quiet;
    @(posedge sys_clk_i) disable iff (reset_i)
      !busy_o |-> sock_a_even_byte_en_n_o && sock_a_odd_byte_en_n_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("byte enable active while idle");
  property p_release;
    @(posedge sys_clk_i) disable iff (reset_i)
      done_o |-> sock_a_even_byte_en_n_o && sock_a_odd_byte_en_n_o;
  endproperty
  a_release: assert property (p_release) else $error("byte enable held past completion");
  // wait: no completion while it is low, none before the synchroniser has caught up
  // with clock enable low the flops hold, so the pulse check looks only at enabled edges
  property p_wait;
    @(posedge sys_clk_i) disable iff (reset_i)
      s_held |=> !done_o;
  endproperty
  a_wait: assert property (p_wait) else $error("completed while wait low");
  property p_wait_min;
    @(posedge sys_clk_i) disable iff (reset_i)
      s_start |=> (!done_o) [*3];
  endproperty
  a_wait_min: assert property (p_wait_min) else $error("completed before wait could be seen");
  property p_done_pulse;
    @(posedge sys_clk_i) disable iff (reset_i)
      done_o && clk_en_i |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("completion pulse longer than one cycle");
  // input-port lines: levels follow the pins
  property p_level;
    @(posedge sys_clk_i) disable iff (reset_i) clk_en_i |=> pin_input_level_reg_o == $past(ip_sync_ff);
  endproperty
  a_level: assert property (p_level) else $error("level register stale");
  // set wins over clear, so every line that moved must be flagged at the next edge
  property p_change;
    @(posedge sys_clk_i) disable iff (reset_i) clk_en_i && (ip_sync_ff != level_ff)
      |=> (pin_status_change_reg_o & $past(ip_sync_ff ^ level_ff)) == $past(ip_sync_ff ^ level_ff);
  endproperty
  a_change: assert property (p_change) else $error("line change not recorded");
  // port size is taken at an i/o start; a wide access opens both lanes
  property p_io16;
    @(posedge sys_clk_i) disable iff (reset_i)
      (s_start and req_i.is_io) |=> io16_o == $past(ip_sync_ff[csa_pkg::IOIS16_BIT]);
  endproperty
  a_io16: assert property (p_io16) else $error("port size not sampled");
  property p_wide;
    @(posedge sys_clk_i) disable iff (reset_i) (s_start and wide_now)
      |=> !sock_a_even_byte_en_n_o && !sock_a_odd_byte_en_n_o;
  endproperty
  a_wide: assert property (p_wide) else $error("16-bit access lacks both enables");
endmodule // csa_port
`default_nettype wire

/* pkg/csa_pkg.sv */
// package for the socket-A card port: constants, states and carrier structs
package csa_pkg;
  localparam int unsigned IP_WIDTH = 8;
  localparam int unsigned IOIS16_BIT = 2; // input-port line shared with the port-size input
  localparam logic [7:0] IP_RESET = 8'h00;
  // access request from the card controller core
  typedef struct packed {
    logic is_io;    // 1: i/o region, 0: memory region
    logic addr_lsb; // lowest address bit
    logic wide;     // memory access asks for 16 bits
  } csa_req_s;
  // state of one card transaction
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } csa_state_e;
endpackage

/* dv/csa_card_model.sv */
// card model for socket A: wait stretch and input-port pin levels
`timescale 1ns/1ps
`default_nettype none
module csa_card_model (
  input wire logic sys_clk_i, // system clock
  input wire logic strobe_i, // address latch strobe seen on the socket
  input wire logic [7:0] stall_i, // cycles to hold wait after the strobe
  input wire logic [7:0] lines_i, // levels the card puts on its pins
  output logic wait_n_o, // wait pin, low stretches
  output logic [7:0] port_o // input-port pins, bit 2 reports port size
);
  logic [7:0] left_ff = 8'h00;
  // wait falls with the strobe so the port's synchroniser sees it early
  assign wait_n_o = !((strobe_i && stall_i != 8'h00) || left_ff != 8'h00);
  assign port_o = lines_i;
  // countdown of the stretch; a released wait line is pulled high
  always_ff @(posedge sys_clk_i) begin
    left_ff <= strobe_i ? stall_i : (left_ff != 8'h00 ? left_ff - 8'h01 : 8'h00);
  end
endmodule // csa_card_model
`default_nettype wire

/* dv/csa_port_tb.sv */
// testbench for the socket-A card port
`timescale 1ns/1ps
`default_nettype none
module csa_port_tb;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en = 1'b1;
  logic req_valid_i = 1'b0;
  csa_pkg::csa_req_s req_i = '0;
  logic [7:0] change_clr_i = 8'h00;
  logic [7:0] stall = 8'h00;
  logic [7:0] lines = 8'h00;
  logic wait_n, busy, done, strobe, even_n, odd_n, io16;
  logic [7:0] port, level, change;
  int mismatches = 0;
  int comparisons = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  csa_port dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en), .req_valid_i(req_valid_i),
    .req_i(req_i), .wait_n_i(wait_n), .input_port_i(port), .change_clr_i(change_clr_i), .busy_o(busy),
    .done_o(done), .sock_a_addr_latch_o(strobe), .sock_a_even_byte_en_n_o(even_n),
    .sock_a_odd_byte_en_n_o(odd_n), .io16_o(io16), .pin_input_level_reg_o(level),
    .pin_status_change_reg_o(change));
  csa_card_model card_u (.sys_clk_i(sys_clk_i), .strobe_i(strobe), .stall_i(stall), .lines_i(lines),
    .wait_n_o(wait_n), .port_o(port));
  ////////////////////////////////////////////////////////////////////////
  // one comparison; a flag that is unknown counts as a mismatch
  task chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // levels follow the pins, changes stick until cleared
  task port_lines;
    change_clr_i = 8'hff;
    @(negedge sys_clk_i) change_clr_i = 8'h00;
    lines = 8'ha5;
    repeat (5) @(negedge sys_clk_i);
    chk(level === 8'ha5, "level register");
    chk(change === 8'ha5, "change flags");
    change_clr_i = 8'hff;
    @(negedge sys_clk_i) change_clr_i = 8'h00;
    @(negedge sys_clk_i) chk(change === 8'h00, "change clear");
    lines = 8'h5a;
    repeat (5) @(negedge sys_clk_i);
    chk(change === 8'hff && level === 8'h5a, "every line flagged");
    // a clear that meets a fresh edge in the same cycle loses to it
    change_clr_i = 8'hff;
    @(negedge sys_clk_i) change_clr_i = 8'h00;
    lines = 8'h5b;
    repeat (2) @(negedge sys_clk_i);
    change_clr_i = 8'hff;
    @(negedge sys_clk_i) change_clr_i = 8'h00;
    chk(change === 8'h01, "set lost to clear");
    // clock enable low freezes levels and flags; they catch up once it returns
    clk_en = 1'b0;
    lines = 8'h00;
    repeat (5) @(negedge sys_clk_i);
    chk(level === 8'h5b && change === 8'h01, "state moved while frozen");
    clk_en = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk(level === 8'h00 && change === 8'h5b, "levels after thaw");
    $display("test port lines done");
  endtask
  // one card access with the given width source and wait stretch
  task access(input logic io, input logic lsb, input logic wd, input logic p16, input logic [7:0] st);
    logic w;
    int n;
    w = io ? p16 : wd;
    lines = {5'h00, p16, 2'h0};
    stall = st;
    repeat (4) @(negedge sys_clk_i);
    req_valid_i = 1'b1;
    req_i = '{io, lsb, wd};
    @(negedge sys_clk_i) chk(strobe === 1'b1 && busy === 1'b1, "strobe missing");
    chk(even_n === !(w || !lsb) && odd_n === !(w || lsb), "byte enables");
    // valid stays up one more cycle: a request while busy must be dropped, not taken again
    @(negedge sys_clk_i) req_valid_i = 1'b0;
    chk(strobe === 1'b0, "strobe too long");
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge sys_clk_i) n++;
    end
    chk(done === 1'b1 && n >= int'(st), "completion while wait low");
    if (done !== 1'b1) summarize;
    chk(even_n === 1'b1 && odd_n === 1'b1, "enables held past completion");
    if (io) chk(io16 === p16, "port size");
    @(negedge sys_clk_i) chk(busy === 1'b0 && done === 1'b0, "not idle after completion");
    $display("test access done");
  endtask
  // reset in mid-access: every output returns to its idle value at the next clock edge
  task reset_mid;
    lines = 8'h24;
    stall = 8'h04;
    repeat (4) @(negedge sys_clk_i);
    req_valid_i = 1'b1;
    req_i = '{1'b0, 1'b0, 1'b1};
    @(negedge sys_clk_i) req_valid_i = 1'b0;
    reset_i = 1'b1;
    @(negedge sys_clk_i) chk(busy === 1'b0 && strobe === 1'b0 && even_n === 1'b1 && odd_n === 1'b1, "outputs in reset");
    chk(level === 8'h00 && change === 8'h00 && done === 1'b0 && io16 === 1'b0, "registers in reset");
    reset_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(busy === 1'b0 && strobe === 1'b0 && even_n === 1'b1 && odd_n === 1'b1, "idle after release");
    $display("test mid-run reset done");
  endtask
  initial begin
    repeat (4) @(negedge sys_clk_i);
    reset_i = 1'b0;
    port_lines;
    access(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    access(1'b0, 1'b1, 1'b0, 1'b0, 8'h03);
    access(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    access(1'b1, 1'b1, 1'b0, 1'b1, 8'h05);
    access(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    access(1'b1, 1'b1, 1'b1, 1'b0, 8'h02);
    reset_mid;
    access(1'b0, 1'b1, 1'b0, 1'b0, 8'h01);
    summarize;
  end
endmodule // csa_port_tb
`default_nettype wire
